// ### core/dbo_pkg.sv
// Function
// - A buffer in amplifier mode acts standalone; its converter output path is off.
// - Config bit 0 routes analog in 0/1 as plus/minus, output on converter out 0.
// - Config bit 1 routes analog in 2/3 as plus/minus, output on converter out 1.
// - Config bit 2 routes analog in 4/5 as plus/minus, output on converter out 2.
// - Config bit 3 routes analog in 8/9 as plus/minus, output on converter out 3.
// - A clear config bit leaves that buffer in its normal converter role.
// - Config changes only through first key 0x9A, value, then second key 0x0C.
// - Range field 00 powers the converter down and, in its normal role, floats its output.
package dbo_pkg;
  localparam logic [31:0] ADDR_FIRST_KEY = 32'hffff_0650;
  localparam logic [31:0] ADDR_CONFIG = 32'hffff_0654;
  localparam logic [31:0] ADDR_SECOND_KEY = 32'hffff_0658;
  localparam logic [31:0] ADDR_CONV_BASE = 32'hffff_0600;
  localparam logic [31:0] ADDR_CONV_STEP = 32'h0000_0008;
  localparam logic [15:0] FIRST_KEY_VALUE = 16'h009a;
  localparam logic [15:0] SECOND_KEY_VALUE = 16'h000c;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CONV_CTRL_RESET = 8'h00;
  localparam logic [3:0] CONFIG_USED_MASK = 4'hf;
  localparam logic [7:0] CONV_CTRL_MASK = 8'h73;
  localparam logic [1:0] RANGE_OFF = 2'h0;
  localparam int NUM_CONV = 4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum {DBO_IDLE, DBO_KEYED, DBO_STAGED} dbo_unlock_e;

  typedef struct packed {
    logic amp_en;
    logic conv_path_en;
    logic out_drive_en;
    logic [1:0] range;
  } dbo_chan_s;

  typedef struct packed {
    logic plus_sel;
    logic minus_sel;
  } dbo_route_s;
endpackage : dbo_pkg

// ### core/dbo_channel.sv
`timescale 1ns/10ps
module dbo_channel (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Controls.
  input wire logic amp_mode,
  input wire logic [1:0] range,
  // Outputs.
  output dbo_pkg::dbo_chan_s chan,
  output dbo_pkg::dbo_route_s route
);
  import dbo_pkg::*;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chan <= '0;
      route <= '0;
    end else begin
      chan.amp_en <= amp_mode;
      chan.conv_path_en <= !amp_mode && (range != RANGE_OFF);
      chan.out_drive_en <= amp_mode || (range != RANGE_OFF);
      chan.range <= range;
      route.plus_sel <= amp_mode;
      route.minus_sel <= amp_mode;
    end
  end
endmodule : dbo_channel

// ### core/dbo_top.sv
`timescale 1ns/10ps
module dbo_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Per converter channel state and analog routing.
  output dbo_pkg::dbo_chan_s [3:0] chan,
  output dbo_pkg::dbo_route_s [3:0] route
);
  import dbo_pkg::*;

  // Software reaches three registers here: two write-only keys and the buffer configuration.
  // A new configuration is staged by a write that directly follows the first key and goes live
  // only when the second key comes next; any other write in between throws the staged value away.
  // The converter control registers also live here, because their range field decides whether a
  // converter in its normal role drives its output or leaves it floating.
  // Channel state is registered once more in each channel, so outputs change one edge after
  // the write data edge that causes them.

  // Captured address phase, held for the data phase that follows.
  logic ph_valid;
  logic ph_write;
  logic [31:0] ph_addr;

  // Address phase decode, ahead of the capture.
  logic addr_take;
  logic addr_read;

  // Data phase decode of the captured address and of the write data.
  logic hit_first_key;
  logic hit_config;
  logic hit_second_key;
  logic [NUM_CONV-1:0] hit_conv;
  logic first_key_ok;
  logic second_key_ok;

  // Register state.
  logic [3:0] config_bits;
  logic [3:0] staged;
  logic [7:0] conv_ctrl [NUM_CONV];
  dbo_unlock_e unlock;

  // Data phase strobes and the read path.
  logic wr_now;
  logic rd_now;
  logic [31:0] next_rdata;

  // Only single word transfers are taken; other sizes pass as idle cycles.
  assign addr_take = hready && hsel && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
  assign addr_read = addr_take && !hwrite;

  // Writes finish with no wait state, so write data is taken at the first data phase edge.
  assign wr_now = ph_valid && ph_write && hready;

  // A read loads hrdata during its wait state, after every earlier write has landed.
  assign rd_now = ph_valid && !ph_write && !hreadyout;

  // Register decode of the captured address.
  assign hit_first_key = (ph_addr == ADDR_FIRST_KEY);
  assign hit_config = (ph_addr == ADDR_CONFIG);
  assign hit_second_key = (ph_addr == ADDR_SECOND_KEY);

  // Keys are compared on the low halfword only.
  assign first_key_ok = hit_first_key && (hwdata[15:0] == FIRST_KEY_VALUE);
  assign second_key_ok = hit_second_key && (hwdata[15:0] == SECOND_KEY_VALUE);

  // Address phase capture; a stalled bus keeps the pending transfer.
  // The captured fields stay put through a read's wait state, when hready is low.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_valid <= 1'b0;
    end else if (hready) begin
      ph_valid <= addr_take;
    end
  end

  // Direction of the captured transfer.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_write <= 1'b0;
    end else if (hready) begin
      ph_write <= hwrite;
    end
  end

  // Address of the captured transfer.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_addr <= '0;
    end else if (hready) begin
      ph_addr <= haddr;
    end
  end

  // Reads take one wait state, so hrdata comes from a flip-flop and still reflects
  // the write that finished just before the read's data phase.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !addr_read;
    end
  end

  // Every response is OKAY: refused writes are dropped quietly rather than flagged.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Unlock sequence: first key, configuration value, second key, with no other write between.
  // Any write elsewhere, converter controls included, sends it back to idle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unlock <= DBO_IDLE;
    end else if (wr_now) begin
      case (unlock)
        // Waiting for the first key.
        DBO_IDLE: begin
          if (first_key_ok) begin
            unlock <= DBO_KEYED;
          end
        end
        // First key seen; a repeated first key keeps the sequence open.
        DBO_KEYED: begin
          if (hit_config) begin
            unlock <= DBO_STAGED;
          end else if (!first_key_ok) begin
            unlock <= DBO_IDLE;
          end
        end
        // Value staged; the next write ends the sequence either way.
        DBO_STAGED: begin
          unlock <= DBO_IDLE;
        end
        default: begin
          unlock <= DBO_IDLE;
        end
      endcase
    end
  end

  // The staged value is held apart, so a sequence that breaks off leaves the live configuration untouched.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      staged <= CONFIG_RESET[3:0];
    end else if (wr_now && hit_config && (unlock == DBO_KEYED)) begin
      staged <= hwdata[3:0];
    end
  end

  // The live configuration changes only on a correct second key right after the staged value.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      config_bits <= CONFIG_RESET[3:0];
    end else if (wr_now && second_key_ok && (unlock == DBO_STAGED)) begin
      config_bits <= staged & CONFIG_USED_MASK;
    end
  end

  // Converter control registers; the range field in bits 1:0 feeds each channel.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CONV; gi++) begin : g_conv
      assign hit_conv[gi] = (ph_addr == ADDR_CONV_BASE + ADDR_CONV_STEP * 32'(gi));

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          conv_ctrl[gi] <= CONV_CTRL_RESET;
        end else if (wr_now && hit_conv[gi]) begin
          conv_ctrl[gi] <= hwdata[7:0] & CONV_CTRL_MASK;
        end
      end

      // Each channel registers its own state and routing.
      dbo_channel u_chan (
        .clk(clk),
        .rst_b(rst_b),
        .amp_mode(config_bits[gi]),
        .range(conv_ctrl[gi][1:0]),
        .chan(chan[gi]),
        .route(route[gi])
      );
    end
  endgenerate

  // Read mux; the keys, reserved bits and unmapped addresses read zero.
  always_comb begin
    next_rdata = '0;
    if (hit_config) begin
      next_rdata = {28'h000_0000, config_bits};
    end
    for (int i = 0; i < NUM_CONV; i++) begin
      if (hit_conv[i]) begin
        next_rdata = {24'h00_0000, conv_ctrl[i]};
      end
    end
  end

  // hrdata only changes in a read's wait state and holds until the next read.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= '0;
    end else if (rd_now) begin
      hrdata <= next_rdata;
    end
  end
endmodule : dbo_top

// ### tb/dbo_properties.sv
`timescale 1ns/10ps
module dbo_properties (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Channel outputs.
  input dbo_pkg::dbo_chan_s [3:0] chan,
  input dbo_pkg::dbo_route_s [3:0] route,
  // Bus side.
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp
);
  import dbo_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  route_zero_a: assert property (route[0] == {2{chan[0].amp_en}}) else $error("route 0 bad");
  route_one_a: assert property (route[1] == {2{chan[1].amp_en}}) else $error("route 1 bad");
  route_two_a: assert property (route[2] == {2{chan[2].amp_en}}) else $error("route 2 bad");
  route_three_a: assert property (route[3] == {2{chan[3].amp_en}}) else $error("route 3 bad");
  amp_path_off_a: assert property (chan[0].amp_en |-> !chan[0].conv_path_en) else $error("path on");
  normal_path_a: assert property (!chan[1].amp_en |-> chan[1].conv_path_en == (chan[1].range != 2'h0))
    else $error("normal path bad");
  range_float_a: assert property (!chan[2].amp_en && chan[2].range == RANGE_OFF |-> !chan[2].out_drive_en)
    else $error("output driven");
  reset_clear_a: assert property ($rose(rst_b) |-> chan[3].amp_en == 1'h0 && chan[0].amp_en == 1'h0)
    else $error("config not cleared");
  sequence read_taken_s;
    hready && hsel && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD) && !hwrite;
  endsequence
  sequence one_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  read_wait_a: assert property (read_taken_s |=> one_wait_s) else $error("read wait state wrong");
  bus_okay_a: assert property (!hresp) else $error("error response");
endmodule : dbo_properties

bind dbo_top dbo_properties u_prop (.clk(clk), .rst_b(rst_b), .chan(chan), .route(route), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp));

// ### tb/tb_dbo_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t got %h", $time, a); end end
module tb_dbo_top;
  import dbo_pkg::*;
  logic clk, rst_b, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [3:0] cfg;
  logic [1:0] rng [4];
  dbo_chan_s [3:0] chan;
  dbo_route_s [3:0] route;
  int errors, compares;
  dbo_top DUT (.clk(clk), .rst_b(rst_b), .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .chan(chan), .route(route));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task report_and_stop;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  function automatic dbo_chan_s exp_chan(input logic amp, input logic [1:0] r);
    exp_chan.amp_en = amp;
    exp_chan.conv_path_en = !amp && (r != RANGE_OFF);
    exp_chan.out_drive_en = amp || (r != RANGE_OFF);
    exp_chan.range = r;
  endfunction : exp_chan
  task check_outputs;
    repeat (2) @(posedge clk);
    for (int i = 0; i < NUM_CONV; i++) begin
      `CHK(chan[i], exp_chan(cfg[i], rng[i]))
      `CHK(route[i], {2{cfg[i]}})
    end
  endtask : check_outputs
  // Read data is taken at the edge that ends the data phase, as hready is sampled high.
  task xfer(input logic [31:0] a, input logic [31:0] d, input logic w, input logic [31:0] e);
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    if (!w) begin
      `CHK(hrdata, e)
    end
  endtask : xfer
  task unlock(input logic [31:0] d, input int m);
    if (m != 1) xfer(ADDR_FIRST_KEY, {16'h0000, FIRST_KEY_VALUE}, 1'h1, 32'h0);
    xfer(ADDR_CONFIG, d, 1'h1, 32'h0);
    if (m == 2) xfer(32'hffff_0700, d, 1'h1, 32'h0);
    xfer(ADDR_SECOND_KEY, {16'h0000, SECOND_KEY_VALUE}, 1'h1, 32'h0);
    if (m == 0) cfg = d[3:0];
  endtask : unlock
  initial begin
    #200000;
    errors++;
    report_and_stop;
  end
  initial begin
    rst_b = 1'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    cfg = 4'h0;
    foreach (rng[i]) rng[i] = 2'h0;
    v = $urandom(33);
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    xfer(ADDR_FIRST_KEY, 32'h0, 1'h0, 32'h0);
    xfer(ADDR_SECOND_KEY, 32'h0, 1'h0, 32'h0);
    xfer(ADDR_CONFIG, 32'h0, 1'h0, 32'h0);
    $display("reset test done");
    for (int n = 0; n < 24; n++) begin
      v = $urandom & 32'h0000_0073;
      xfer(ADDR_CONV_BASE + ADDR_CONV_STEP * 32'(n % 4), v, 1'h1, 32'h0);
      rng[n % 4] = v[1:0];
      xfer(ADDR_CONV_BASE + ADDR_CONV_STEP * 32'(n % 4), 32'h0, 1'h0, v);
      unlock($urandom & 32'h0000_000f, n % 3);
      xfer(ADDR_CONFIG, 32'h0, 1'h0, {28'h0, cfg});
      check_outputs;
      `CHK({chan[3].amp_en, chan[2].amp_en, chan[1].amp_en, chan[0].amp_en}, cfg)
    end
    unlock(32'h0000_0001, 0);
    xfer(ADDR_CONV_BASE, 32'h0000_0010, 1'h1, 32'h0);
    rng[0] = 2'h0;
    check_outputs;
    $display("unlock test done");
    xfer(ADDR_FIRST_KEY, {16'h0000, FIRST_KEY_VALUE}, 1'h1, 32'h0);
    xfer(ADDR_CONFIG, 32'h0000_000f, 1'h1, 32'h0);
    rst_b <= 1'h0;
    @(posedge clk);
    rst_b <= 1'h1;
    cfg = 4'h0;
    foreach (rng[i]) rng[i] = 2'h0;
    @(posedge clk);
    xfer(ADDR_SECOND_KEY, {16'h0000, SECOND_KEY_VALUE}, 1'h1, 32'h0);
    xfer(ADDR_CONFIG, 32'h0, 1'h0, 32'h0);
    check_outputs;
    $display("abort test done");
    report_and_stop;
  end
endmodule : tb_dbo_top
